// >>> hw/ufrt_top.sv
// Frame timer of a USB host: registers, frame sequence and priority outputs
// Contract
// - Hold 14-bit frame length in 12 MHz clocks, reset 2EDFh.
// - Provide read/write 15-bit largest full-speed packet size in bit times.
// - On every countdown reload copy interval toggle into remaining toggle.
// - Read-only 14-bit bits-left count, reloaded from frame length each frame.
// - Read-only 16-bit frame counter increments when countdown reloads.
// - Frame counter wraps from FFFFh to zero by itself.
// - After increment publish count to memory, set start-of-frame status, start lists.
// - Hold 14-bit periodic threshold where periodic lists gain priority.
// - Control and bulk first, periodic lists for the remaining 90% of frame.
// - Low-speed transaction may start only while bits left exceed cutoff.
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ufrt_top
  import ufrt_pkg::*;
(
  input  wire logic              core_clk,          // Core clock, 10 MHz
  input  wire logic              reset_n,           // Asynchronous reset, active low
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,      // Write address
  input  wire logic              s_axi_awvalid,     // Write address valid
  output logic                   s_axi_awready,     // Write address ready
  input  wire logic [31:0]       s_axi_wdata,       // Write data
  input  wire logic [3:0]        s_axi_wstrb,       // Write byte strobes
  input  wire logic              s_axi_wvalid,      // Write data valid
  output logic                   s_axi_wready,      // Write data ready
  output logic [1:0]             s_axi_bresp,       // Write response
  output logic                   s_axi_bvalid,      // Write response valid
  input  wire logic              s_axi_bready,      // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,      // Read address
  input  wire logic              s_axi_arvalid,     // Read address valid
  output logic                   s_axi_arready,     // Read address ready
  output logic [31:0]            s_axi_rdata,       // Read data
  output logic [1:0]             s_axi_rresp,       // Read response
  output logic                   s_axi_rvalid,      // Read data valid
  input  wire logic              s_axi_rready,      // Read data ready
  // Frame timing
  input  wire logic              bit_tick,          // Bit-time strobe, same clock
  input  wire logic              hca_wr_ready,      // Memory took the frame number
  output logic                   hca_wr_valid,      // Frame number write request
  output logic [FNUM_W-1:0]      hca_wr_data,       // Frame number to memory
  output logic                   list_walk_start,   // Pulse: start descriptor lists
  output logic                   periodic_priority, // Periodic lists have priority
  output logic                   lowspeed_ok,       // Low-speed start allowed
  output logic [14:0]            max_packet_bits,   // Largest full-speed packet
  output logic                   irq                // Interrupt, active high level
);

  typedef struct packed {
    logic              aw_rdy;
    logic              w_rdy;
    logic              bvalid;
    logic              ar_rdy;
    logic              rvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [31:0]       fl_cfg;
    logic [LEN_W-1:0]  ps;
    logic [LEN_W-1:0]  ls;
    logic [INT_W-1:0]  int_status;
    logic [INT_W-1:0]  int_mask;
    ufrt_seq_e         seq;
    logic              hca_valid;
    logic [FNUM_W-1:0] hca_data;
    logic              walk;
    logic              periodic_pri;
    logic              ls_ok;
    logic              irq;
  } ufrt_top_s;

  ufrt_top_s st_reg;
  ufrt_top_s st_next;

  ufrt_frame_if fi ();

  // Merge a write into an old word under byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Widen a 14-bit setting to a bus word; upper bits read as zero
  function automatic logic [31:0] len_word(input logic [LEN_W-1:0] v);
    logic [31:0] res;
    res            = '0;
    res[LEN_W-1:0] = v;
    return res;
  endfunction

  // Widen an interrupt field to a bus word; upper bits read as zero
  function automatic logic [31:0] int_word(input logic [INT_W-1:0] v);
    logic [31:0] res;
    res            = '0;
    res[INT_W-1:0] = v;
    return res;
  endfunction

  // Byte-merged write of a 14-bit setting
  function automatic logic [LEN_W-1:0] len_update(input logic [LEN_W-1:0] old_v,
                                                  input logic [31:0]      new_v,
                                                  input logic [3:0]       strb);
    logic [31:0] res;
    res = merge_strb(len_word(old_v), new_v, strb);
    return res[LEN_W-1:0];
  endfunction

  // Byte-merged write of an interrupt field
  function automatic logic [INT_W-1:0] int_update(input logic [INT_W-1:0] old_v,
                                                  input logic [31:0]      new_v,
                                                  input logic [3:0]       strb);
    logic [31:0] res;
    res = merge_strb(int_word(old_v), new_v, strb);
    return res[INT_W-1:0];
  endfunction

  // Countdown and frame number
  ufrt_countdown u_countdown (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .bit_tick (bit_tick),
    .fi       (fi)
  );

  // Settings handed to the countdown
  assign fi.frame_len       = st_reg.fl_cfg[FLC_LEN_MSB:FLC_LEN_LSB];
  assign fi.interval_toggle = st_reg.fl_cfg[FLC_TOGGLE_BIT];

  // Next-state logic for bus, registers, frame sequence and interrupts
  always_comb begin
    logic [31:0]      merged;
    logic [INT_W-1:0] clr;
    logic [INT_W-1:0] set_bits;
    logic             do_write;
    merged   = '0;
    clr      = '0;
    set_bits = '0;
    do_write = 1'b0;
    st_next      = st_reg;
    st_next.walk = 1'b0;

    // Write address and data are taken independently
    if (s_axi_awvalid && st_reg.aw_rdy) begin
      st_next.aw_rdy = 1'b0;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.w_rdy) begin
      st_next.w_rdy = 1'b0;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end

    // Perform the write once both halves are held
    do_write = !st_reg.aw_rdy && !st_reg.w_rdy && !st_reg.bvalid;
    if (do_write) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = RESP_OKAY;
      case (st_reg.awaddr)
        OFS_FRAME_LEN: begin
          merged         = merge_strb(st_reg.fl_cfg, st_reg.wdata, st_reg.wstrb);
          st_next.fl_cfg = merged & FLC_WR_MASK;
        end
        OFS_PERIODIC: begin
          st_next.ps = len_update(st_reg.ps, st_reg.wdata, st_reg.wstrb);
        end
        OFS_LOWSPEED: begin
          st_next.ls = len_update(st_reg.ls, st_reg.wdata, st_reg.wstrb);
        end
        OFS_INT_STATUS: begin
          if (st_reg.wstrb[0]) begin
            clr = st_reg.wdata[INT_W-1:0];
          end
        end
        OFS_INT_MASK: begin
          st_next.int_mask = int_update(st_reg.int_mask, st_reg.wdata, st_reg.wstrb);
        end
        OFS_BITS_LEFT, OFS_FRAME_CNT: begin
          st_next.bresp = RESP_OKAY; // Read-only, write ignored
        end
        default: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Write response accepted, reopen both channels
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.aw_rdy = 1'b1;
      st_next.w_rdy  = 1'b1;
    end

    // Read: data formed at the edge the address is taken
    if (s_axi_arvalid && st_reg.ar_rdy) begin
      st_next.ar_rdy = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_FRAME_LEN:  st_next.rdata = st_reg.fl_cfg;
        OFS_BITS_LEFT:  st_next.rdata = {fi.remaining_toggle, 17'h0, fi.bits_left};
        OFS_FRAME_CNT:  st_next.rdata = {16'h0, fi.frame_counter};
        OFS_PERIODIC:   st_next.rdata = len_word(st_reg.ps);
        OFS_LOWSPEED:   st_next.rdata = len_word(st_reg.ls);
        OFS_INT_STATUS: st_next.rdata = int_word(st_reg.int_status);
        OFS_INT_MASK:   st_next.rdata = int_word(st_reg.int_mask);
        default: begin
          st_next.rdata = '0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.ar_rdy = 1'b1;
    end

    // Frame start sequence: publish number, set status, start lists
    case (st_reg.seq)
      SEQ_IDLE: begin
        if (fi.frame_start) begin
          st_next.seq       = SEQ_PUBLISH;
          st_next.hca_valid = 1'b1;
          st_next.hca_data  = fi.frame_counter;
        end
      end
      SEQ_PUBLISH: begin
        if (hca_wr_ready) begin
          st_next.hca_valid = 1'b0;
          st_next.seq       = SEQ_STATUS;
        end
      end
      SEQ_STATUS: begin
        st_next.seq = SEQ_WALK;
      end
      SEQ_WALK: begin
        st_next.walk = 1'b1;
        st_next.seq  = SEQ_IDLE;
      end
      default: begin
        st_next.seq = SEQ_IDLE;
      end
    endcase

    // Sticky status: a set in the same cycle beats the clear
    set_bits[INT_SOF_BIT]  = (st_reg.seq == SEQ_STATUS);
    set_bits[INT_WRAP_BIT] = fi.count_wrap;
    st_next.int_status     = (st_reg.int_status & ~clr) | set_bits;

    // Priority windows within the frame
    st_next.periodic_pri = (fi.bits_left <= st_reg.ps);
    st_next.ls_ok        = (fi.bits_left > st_reg.ls);
    st_next.irq          = |(st_reg.int_status & st_reg.int_mask);
  end

  // State register with constant reset values
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg        <= '0;
      st_reg.aw_rdy <= 1'b1;
      st_reg.w_rdy  <= 1'b1;
      st_reg.ar_rdy <= 1'b1;
      st_reg.fl_cfg <= FLC_RESET;
      st_reg.ps     <= PS_RESET;
      st_reg.ls     <= LS_RESET;
      st_reg.seq    <= SEQ_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready     = st_reg.aw_rdy;
  assign s_axi_wready      = st_reg.w_rdy;
  assign s_axi_bresp       = st_reg.bresp;
  assign s_axi_bvalid      = st_reg.bvalid;
  assign s_axi_arready     = st_reg.ar_rdy;
  assign s_axi_rdata       = st_reg.rdata;
  assign s_axi_rresp       = st_reg.rresp;
  assign s_axi_rvalid      = st_reg.rvalid;
  assign hca_wr_valid      = st_reg.hca_valid;
  assign hca_wr_data       = st_reg.hca_data;
  assign list_walk_start   = st_reg.walk;
  assign periodic_priority = st_reg.periodic_pri;
  assign lowspeed_ok       = st_reg.ls_ok;
  assign max_packet_bits   = st_reg.fl_cfg[FLC_MPS_MSB:FLC_MPS_LSB];
  assign irq               = st_reg.irq;

endmodule // ufrt_top
`default_nettype wire

// >>> hw/ufrt_pkg.sv
// Package of constants and types for the USB host frame timer
package ufrt_pkg;

  // Register bus geometry
  localparam int          ADDR_W          = 8;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // Register byte offsets
  localparam logic [7:0]  OFS_FRAME_LEN   = 8'h00;
  localparam logic [7:0]  OFS_BITS_LEFT   = 8'h04;
  localparam logic [7:0]  OFS_FRAME_CNT   = 8'h08;
  localparam logic [7:0]  OFS_PERIODIC    = 8'h0c;
  localparam logic [7:0]  OFS_LOWSPEED    = 8'h10;
  localparam logic [7:0]  OFS_INT_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_INT_MASK    = 8'h18;

  // Frame length configuration layout
  localparam int          FLC_TOGGLE_BIT  = 31;
  localparam int          FLC_MPS_MSB     = 30;
  localparam int          FLC_MPS_LSB     = 16;
  localparam int          FLC_LEN_MSB     = 13;
  localparam int          FLC_LEN_LSB     = 0;
  localparam logic [31:0] FLC_WR_MASK     = 32'hffff3fff;
  localparam logic [31:0] FLC_RESET       = 32'h00002edf;

  // Widths of counters and thresholds
  localparam int          LEN_W           = 14;
  localparam int          FNUM_W          = 16;
  localparam int          INT_W           = 2;
  localparam logic [13:0] PS_RESET        = 14'h0000;
  localparam logic [13:0] LS_RESET        = 14'h0628;
  localparam logic [13:0] BITS_ZERO       = 14'h0000;
  localparam logic [13:0] BITS_ONE        = 14'h0001;
  localparam logic [15:0] FNUM_ONE        = 16'h0001;
  localparam logic [15:0] FNUM_MAX        = 16'hffff;

  // Interrupt status bit positions
  localparam int          INT_SOF_BIT     = 0;
  localparam int          INT_WRAP_BIT    = 1;

  // Sequence after each frame start
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_PUBLISH,
    SEQ_STATUS,
    SEQ_WALK
  } ufrt_seq_e;

endpackage : ufrt_pkg

// >>> hw/ufrt_frame_if.sv
// Interface between register side and frame countdown
`timescale 1ns/100ps
`default_nettype none
interface ufrt_frame_if;
  import ufrt_pkg::*;
  logic [LEN_W-1:0]  frame_len;         // Reload value of the countdown
  logic              interval_toggle;   // Toggle to copy at each reload
  logic [LEN_W-1:0]  bits_left;         // Bit times left in frame
  logic              remaining_toggle;  // Toggle copied at last reload
  logic [FNUM_W-1:0] frame_counter;     // Current frame number
  logic              frame_start;       // One-cycle pulse at reload
  logic              count_wrap;        // One-cycle pulse at number wrap

  modport ctrl  (output frame_len, interval_toggle,
                 input  bits_left, remaining_toggle, frame_counter, frame_start, count_wrap);
  modport count (input  frame_len, interval_toggle,
                 output bits_left, remaining_toggle, frame_counter, frame_start, count_wrap);
endinterface : ufrt_frame_if
`default_nettype wire

// >>> hw/ufrt_countdown.sv
// Frame countdown and frame number counter
`timescale 1ns/100ps
`default_nettype none
module ufrt_countdown
  import ufrt_pkg::*;
(
  input  wire logic  core_clk,   // Core clock
  input  wire logic  reset_n,    // Asynchronous reset, active low
  input  wire logic  bit_tick,   // One full-speed bit time elapsed
  ufrt_frame_if.count fi         // Frame settings and state
);

  typedef struct packed {
    logic [LEN_W-1:0]  bits_left;
    logic              remaining_toggle;
    logic [FNUM_W-1:0] frame_counter;
    logic              frame_start;
    logic              count_wrap;
  } ufrt_cnt_s;

  ufrt_cnt_s cnt_reg;
  ufrt_cnt_s cnt_next;

  // Countdown, reload on zero, frame number advance
  always_comb begin
    cnt_next             = cnt_reg;
    cnt_next.frame_start = 1'b0;
    cnt_next.count_wrap  = 1'b0;
    if (bit_tick) begin
      if (cnt_reg.bits_left == BITS_ZERO) begin
        cnt_next.bits_left        = fi.frame_len;
        cnt_next.remaining_toggle = fi.interval_toggle;
        cnt_next.frame_counter    = cnt_reg.frame_counter + FNUM_ONE;
        cnt_next.frame_start      = 1'b1;
        cnt_next.count_wrap       = (cnt_reg.frame_counter == FNUM_MAX);
      end else begin
        cnt_next.bits_left = cnt_reg.bits_left - BITS_ONE;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Publish state to the register side
  assign fi.bits_left        = cnt_reg.bits_left;
  assign fi.remaining_toggle = cnt_reg.remaining_toggle;
  assign fi.frame_counter    = cnt_reg.frame_counter;
  assign fi.frame_start      = cnt_reg.frame_start;
  assign fi.count_wrap       = cnt_reg.count_wrap;

endmodule // ufrt_countdown
`default_nettype wire

// >>> testbench/ufrt_chk.sv
// Checker of bus handshakes and the frame publication sequence
`timescale 1ns/100ps
`default_nettype none
module ufrt_chk
  import ufrt_pkg::*;
(
  input wire logic              core_clk,        // Clock
  input wire logic              reset_n,         // Reset, active low
  input wire logic              s_axi_awvalid,   // Write address valid
  input wire logic              s_axi_awready,   // Write address ready
  input wire logic              s_axi_wvalid,    // Write data valid
  input wire logic              s_axi_wready,    // Write data ready
  input wire logic [1:0]        s_axi_bresp,     // Write response
  input wire logic              s_axi_bvalid,    // Write response valid
  input wire logic              s_axi_bready,    // Write response ready
  input wire logic              s_axi_arvalid,   // Read address valid
  input wire logic              s_axi_arready,   // Read address ready
  input wire logic [31:0]       s_axi_rdata,     // Read data
  input wire logic [1:0]        s_axi_rresp,     // Read response
  input wire logic              s_axi_rvalid,    // Read data valid
  input wire logic              s_axi_rready,    // Read data ready
  input wire logic              hca_wr_ready,    // Memory took the number
  input wire logic              hca_wr_valid,    // Number write request
  input wire logic [FNUM_W-1:0] hca_wr_data,     // Number to memory
  input wire logic              list_walk_start  // Start of list walk
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Steps after a frame number reaches memory
  sequence s_accept;
    hca_wr_valid && hca_wr_ready;
  endsequence
  sequence s_walk_late;
    ##3 list_walk_start;
  endsequence
  // Frame publication order
  a_walk_after_accept: assert property (s_accept |-> s_walk_late)
    else $error("walk pulse missing after number write");
  a_walk_single_pulse: assert property (list_walk_start |=> !list_walk_start)
    else $error("walk pulse longer than one cycle");
  a_walk_has_cause: assert property (list_walk_start |-> $past(hca_wr_valid && hca_wr_ready, 3))
    else $error("walk pulse without number write");
  a_publish_holds: assert property (hca_wr_valid && !hca_wr_ready |=> hca_wr_valid && $stable(hca_wr_data))
    else $error("number write dropped or changed");
  // Register bus handshakes
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule // ufrt_chk
`default_nettype wire

// >>> testbench/ufrt_hca_mem.sv
// Memory model taking published frame numbers with wait states
`timescale 1ns/100ps
`default_nettype none
module ufrt_hca_mem (
  input  wire logic        core_clk,     // Clock
  input  wire logic        reset_n,      // Reset, active low
  input  wire logic        hca_wr_valid, // Write request
  input  wire logic [15:0] hca_wr_data,  // Frame number
  input  wire logic [1:0]  delay,        // Wait states before taking
  output logic             hca_wr_ready  // Word taken
);
  logic [1:0] wait_reg;
  // Count wait states, then take one word for one cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 2'h0;
      hca_wr_ready <= 1'b0;
    end else begin
      hca_wr_ready <= hca_wr_valid && !hca_wr_ready && wait_reg == delay;
      wait_reg <= (hca_wr_valid && !hca_wr_ready && wait_reg != delay) ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule // ufrt_hca_mem
`default_nettype wire

// >>> testbench/usb_host_frame_timer_bench.sv
// Testbench of the frame timer: registers, frame sequence, priorities, wrap
`timescale 1ns/100ps
`default_nettype none
module usb_host_frame_timer_bench;
  import ufrt_pkg::*;
  logic              core_clk = 1'b0, reset_n = 1'b0, bit_tick = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, mem_delay = 2'h0;
  logic              hca_wr_ready, hca_wr_valid, list_walk_start, periodic_priority, lowspeed_ok, irq;
  logic [15:0]       hca_wr_data, lfsr = 16'h663e; // Seed 26174
  logic [14:0]       max_packet_bits, mps;
  int                num_errors = 0, n_checks = 0, cyc = 0;
  logic [33:0]       rq[$];
  logic [15:0]       hq[$];
  logic [1:0]        bq[$];

  ufrt_top DUT (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_tick, .hca_wr_ready,
    .hca_wr_valid, .hca_wr_data, .list_walk_start, .periodic_priority, .lowspeed_ok, .max_packet_bits, .irq);
  ufrt_hca_mem MEM (.core_clk, .reset_n, .hca_wr_valid, .hca_wr_data, .delay(mem_delay), .hca_wr_ready);

  // Clock of 100 ns
  initial forever #50 core_clk = ~core_clk;

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Bus write: both channels offered together, each released when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (s_axi_awready) aw = 1'b1;
      if (s_axi_wready) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  // Bus read; expectation is response and data together
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic tick(input int n);
    bit_tick <= 1'b1;
    repeat (n) @(posedge core_clk);
    bit_tick <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // Watcher: compares each result with the oldest note, frame numbers only while notes remain, and cuts a hang
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (hca_wr_valid && hca_wr_ready && hq.size() > 0) chk("hca_data", {18'h0, hca_wr_data}, {18'h0, hq.pop_front()});
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // Reset values and an unmapped place
    rd(OFS_FRAME_LEN, {RESP_OKAY, FLC_RESET});
    rd(OFS_BITS_LEFT, {RESP_OKAY, 32'h0});
    rd(OFS_FRAME_CNT, {RESP_OKAY, 32'h0});
    rd(OFS_PERIODIC, {RESP_OKAY, 32'h0});
    rd(OFS_LOWSPEED, {RESP_OKAY, 32'h628});
    rd(8'h1c, {RESP_SLVERR, 32'h0});
    wr(8'h1c, 32'h1, RESP_SLVERR);
    $display("test reset values done");
    // Short frame of 11 ticks, random packet size, toggle inverted
    lfsr = nx(lfsr);
    mps = lfsr[14:0];
    wr(OFS_FRAME_LEN, {1'b1, mps, 16'h000a}, RESP_OKAY);
    rd(OFS_FRAME_LEN, {RESP_OKAY, 1'b1, mps, 16'h000a});
    chk("max_packet_bits", {19'h0, max_packet_bits}, {19'h0, mps});
    wr(OFS_PERIODIC, 32'h9, RESP_OKAY);
    rd(OFS_PERIODIC, {RESP_OKAY, 32'h9});
    wr(OFS_LOWSPEED, 32'h6, RESP_OKAY);
    wr(OFS_INT_MASK, 32'h1, RESP_OKAY);
    $display("test configuration done");
    // Four frames with a slow or prompt memory
    mem_delay <= lfsr[1:0];
    for (int i = 1; i <= 4; i++) hq.push_back(i[15:0]);
    tick(34);
    chk("periodic_priority", {33'h0, periodic_priority}, 34'h0);
    chk("lowspeed_ok", {33'h0, lowspeed_ok}, 34'h1);
    tick(4);
    chk("periodic_priority", {33'h0, periodic_priority}, 34'h1);
    chk("lowspeed_ok", {33'h0, lowspeed_ok}, 34'h0);
    rd(OFS_BITS_LEFT, {RESP_OKAY, 32'h80000006});
    rd(OFS_FRAME_CNT, {RESP_OKAY, 32'h4});
    wr(OFS_FRAME_CNT, 32'hffff, RESP_OKAY);
    rd(OFS_FRAME_CNT, {RESP_OKAY, 32'h4});
    rd(OFS_INT_STATUS, {RESP_OKAY, 32'h1});
    chk("irq", {33'h0, irq}, 34'h1);
    wr(OFS_INT_STATUS, 32'h1, RESP_OKAY);
    rd(OFS_INT_STATUS, {RESP_OKAY, 32'h0});
    chk("irq", {33'h0, irq}, 34'h0);
    $display("test frames done");
    // Length zero: after the six ticks left, every tick reloads, count goes round once
    wr(OFS_FRAME_LEN, {1'b0, mps, 16'h0000}, RESP_OKAY);
    wr(OFS_INT_MASK, 32'h2, RESP_OKAY);
    lfsr = nx(lfsr);
    mem_delay <= lfsr[1:0];
    tick(6 + 65536);
    rd(OFS_FRAME_CNT, {RESP_OKAY, 32'h4});
    rd(OFS_BITS_LEFT, {RESP_OKAY, 32'h0});
    rd(OFS_INT_STATUS, {RESP_OKAY, 32'h3});
    chk("irq", {33'h0, irq}, 34'h1);
    $display("test wrap done");
    // Raise the length by one and let one frame start pick it up
    wr(OFS_FRAME_LEN, {1'b1, mps, 16'h0001}, RESP_OKAY);
    rd(OFS_FRAME_LEN, {RESP_OKAY, 1'b1, mps, 16'h0001});
    tick(1);
    rd(OFS_BITS_LEFT, {RESP_OKAY, 32'h80000001});
    $display("test trim done");
    summarize();
  end
endmodule // usb_host_frame_timer_bench

bind ufrt_top ufrt_chk CHK (.core_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .hca_wr_ready, .hca_wr_valid, .hca_wr_data, .list_walk_start);
`default_nettype wire
